// *** rtl/blink_timer.sv ***
// Tick divider that produces the indicator blink enable pulse.
`timescale 1ns/1ps
module blink_timer #(
  parameter int unsigned PERIOD = 100
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  logic [31:0] count;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count >= PERIOD - 1) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : blink_timer

// *** rtl/lcd_cmd_decoder.sv ***
// Command interpreter for volume, indicator, power save and test commands.
// Function
// - After volume mode only value byte acts.
// - Value byte loads low six level bits.
// - Level load leaves volume mode.
// - Indicator command lowest bit switches on/off.
// - After indicator-on only register byte acts.
// - Indicator code: off, 0.5s, 1s, steady.
// - Only indicator commands and Reset change indicator state.
// - Forced-on while display off enters power save.
// - Sleep left by save-off plus indicator-on.
// - Sleep stops oscillator, supply, grounds outputs.
// - Host interface works in sleep/standby.
// - Standby grounds matrix, keeps indicator running.
// - Reset command in standby enters sleep.
// - Test mode left by pad, Reset or the f0 byte.
// - Power save is display-off plus forced-on.
`timescale 1ns/1ps
module lcd_cmd_decoder #(
  parameter int unsigned HALF_PERIOD = lcd_cmd_pkg::HALF_CYCLES,
  parameter int unsigned ONE_PERIOD = lcd_cmd_pkg::ONE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire lcd_cmd_pkg::host_byte_type host_in,
  output logic [5:0] level_value_bits,
  output logic [1:0] indicator_mode,
  output logic indicator_on,
  output logic indicator_drive_out,
  output logic display_on,
  output logic all_on,
  output logic osc_run,
  output logic supply_run,
  output logic matrix_ground,
  output logic sleep_mode,
  output logic standby_mode,
  output logic test_mode,
  output logic host_port_ready
);
  logic rst_meta;
  logic rst_n;
  logic vol_lock;
  logic ind_lock;
  logic cmd_valid;
  logic [7:0] b;
  logic tick_half;
  logic tick_one;
  logic blink_phase_half;
  logic blink_phase_one;
  logic next_drive;
  logic ind_on_seen;
  lcd_cmd_pkg::power_type power;
  lcd_cmd_pkg::power_type next_power;

  function automatic logic match(input logic [7:0] v, input logic [7:0] m,
                                 input logic [7:0] c);
    match = (v & m) == c;
  endfunction : match

  // Reset is released through two flops so release is glitch free.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign cmd_valid = host_in.valid && !host_in.cmd_data_select;
  assign b = host_in.data;

  // Volume lock: only the value byte can be taken while it is set.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vol_lock <= 1'b0;
      level_value_bits <= lcd_cmd_pkg::LEVEL_RESET;
    end else if (cmd_valid) begin
      if (vol_lock) begin
        level_value_bits <= b[lcd_cmd_pkg::LEVEL_MSB:0];
        vol_lock <= 1'b0;
      end else if (!ind_lock && b == lcd_cmd_pkg::CMD_VOL_MODE) begin
        vol_lock <= 1'b1;
      end else if (!ind_lock && b == lcd_cmd_pkg::CMD_RESET) begin
        level_value_bits <= lcd_cmd_pkg::LEVEL_RESET;
      end
    end
  end

  // Indicator state changes only on the indicator commands and Reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_lock <= 1'b0;
      indicator_on <= 1'b0;
      indicator_mode <= lcd_cmd_pkg::IND_OFF;
    end else if (cmd_valid && !vol_lock) begin
      if (ind_lock) begin
        // The lock has no way to tell a stray command from the register
        // byte, so every byte here is taken as the register value.
        indicator_mode <= b[1:0];
        ind_lock <= 1'b0;
      end else if (match(b, lcd_cmd_pkg::CMD_IND_MASK,
                         lcd_cmd_pkg::CMD_IND)) begin
        indicator_on <= b[lcd_cmd_pkg::SEL_BIT];
        ind_lock <= b[lcd_cmd_pkg::SEL_BIT];
      end else if (b == lcd_cmd_pkg::CMD_RESET) begin
        indicator_mode <= lcd_cmd_pkg::IND_OFF;
      end
    end
  end

  // Display on/off and forced whole-display bits; NOP falls through.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      display_on <= 1'b0;
      all_on <= 1'b0;
    end else if (cmd_valid && !vol_lock && !ind_lock) begin
      if (match(b, lcd_cmd_pkg::CMD_DISP_MASK, lcd_cmd_pkg::CMD_DISP)) begin
        display_on <= b[lcd_cmd_pkg::SEL_BIT];
      end else if (match(b, lcd_cmd_pkg::CMD_DISP_MASK,
                         lcd_cmd_pkg::CMD_ALLON)) begin
        all_on <= b[lcd_cmd_pkg::SEL_BIT];
      end
    end
  end

  // Test mode is entered by bytes f1-ff, left by f0, Reset or pad reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_mode <= 1'b0;
    end else if (cmd_valid && !vol_lock && !ind_lock) begin
      if (b == lcd_cmd_pkg::CMD_RESET || b == lcd_cmd_pkg::CMD_TEST) begin
        test_mode <= 1'b0;
      end else if (match(b, lcd_cmd_pkg::CMD_TEST_MASK,
                         lcd_cmd_pkg::CMD_TEST)) begin
        test_mode <= 1'b1;
      end
    end
  end

  // Sleep must see a fresh indicator-on byte; a switch left on by the
  // Reset path out of standby would otherwise wake the panel by itself.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_on_seen <= 1'b0;
    end else if (power != lcd_cmd_pkg::PWR_SLEEP) begin
      ind_on_seen <= 1'b0;
    end else if (cmd_valid && !vol_lock && !ind_lock &&
                 match(b, lcd_cmd_pkg::CMD_IND_MASK, lcd_cmd_pkg::CMD_IND) &&
                 b[lcd_cmd_pkg::SEL_BIT]) begin
      ind_on_seen <= 1'b1;
    end
  end

  // Power save follows the display-off plus forced-on combination.
  always_comb begin
    next_power = power;
    case (power)
      lcd_cmd_pkg::PWR_RUN: begin
        if (all_on && !display_on) begin
          next_power = indicator_on ? lcd_cmd_pkg::PWR_STANDBY
                                    : lcd_cmd_pkg::PWR_SLEEP;
        end
      end
      lcd_cmd_pkg::PWR_SLEEP: begin
        if ((display_on || !all_on) && ind_on_seen) begin
          next_power = lcd_cmd_pkg::PWR_RUN;
        end
      end
      lcd_cmd_pkg::PWR_STANDBY: begin
        if (cmd_valid && !vol_lock && !ind_lock &&
            b == lcd_cmd_pkg::CMD_RESET) begin
          next_power = lcd_cmd_pkg::PWR_SLEEP;
        end else if (display_on || !all_on) begin
          next_power = lcd_cmd_pkg::PWR_RUN;
        end
      end
      default: next_power = lcd_cmd_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power <= lcd_cmd_pkg::PWR_RUN;
    end else begin
      power <= next_power;
    end
  end

  // Outputs derive from the registered next state to stay flop driven.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_run <= 1'b1;
      supply_run <= 1'b1;
      matrix_ground <= 1'b0;
      sleep_mode <= 1'b0;
      standby_mode <= 1'b0;
      host_port_ready <= 1'b0;
    end else begin
      osc_run <= next_power != lcd_cmd_pkg::PWR_SLEEP;
      supply_run <= next_power == lcd_cmd_pkg::PWR_RUN;
      matrix_ground <= next_power != lcd_cmd_pkg::PWR_RUN;
      sleep_mode <= next_power == lcd_cmd_pkg::PWR_SLEEP;
      standby_mode <= next_power == lcd_cmd_pkg::PWR_STANDBY;
      host_port_ready <= 1'b1;
    end
  end

  // Blink dividers stop with the oscillator in sleep.
  blink_timer #(.PERIOD(HALF_PERIOD)) u_half (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(osc_run),
    .tick(tick_half)
  );

  blink_timer #(.PERIOD(ONE_PERIOD)) u_one (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(osc_run),
    .tick(tick_one)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_phase_half <= 1'b0;
      blink_phase_one <= 1'b0;
    end else begin
      if (tick_half) blink_phase_half <= !blink_phase_half;
      if (tick_one) blink_phase_one <= !blink_phase_one;
    end
  end

  always_comb begin
    next_drive = 1'b0;
    if (indicator_on && power != lcd_cmd_pkg::PWR_SLEEP) begin
      case (indicator_mode)
        lcd_cmd_pkg::IND_HALF: next_drive = blink_phase_half;
        lcd_cmd_pkg::IND_ONE: next_drive = blink_phase_one;
        lcd_cmd_pkg::IND_STEADY: next_drive = 1'b1;
        default: next_drive = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      indicator_drive_out <= 1'b0;
    end else begin
      indicator_drive_out <= next_drive;
    end
  end

  property p_vol_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (cmd_valid && vol_lock) |=> (!vol_lock &&
        level_value_bits == $past(b[5:0]));
  endproperty
  a_vol_load: assert property (p_vol_load) else $error("level load");

  property p_vol_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      vol_lock |=> ($stable(display_on) && $stable(indicator_on));
  endproperty
  a_vol_hold: assert property (p_vol_hold) else $error("vol lock");

  property p_ind_lock;
    @(posedge ref_clk) disable iff (!rst_n)
      (cmd_valid && !vol_lock && !ind_lock && b == 8'had) |=>
        (ind_lock && indicator_on);
  endproperty
  a_ind_lock: assert property (p_ind_lock) else $error("ind lock");

  property p_ind_set;
    @(posedge ref_clk) disable iff (!rst_n)
      (cmd_valid && !vol_lock && ind_lock) |=>
        (!ind_lock && indicator_mode == $past(b[1:0]));
  endproperty
  a_ind_set: assert property (p_ind_set) else $error("ind set");

  property p_sleep;
    @(posedge ref_clk) disable iff (!rst_n)
      (power == lcd_cmd_pkg::PWR_RUN && all_on && !display_on &&
       !indicator_on) |=> ##1 (sleep_mode && !osc_run && matrix_ground);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry");

  property p_standby;
    @(posedge ref_clk) disable iff (!rst_n)
      standby_mode |-> (osc_run && !supply_run && matrix_ground);
  endproperty
  a_standby: assert property (p_standby) else $error("standby");

  property p_reset_sb;
    @(posedge ref_clk) disable iff (!rst_n)
      (power == lcd_cmd_pkg::PWR_STANDBY && cmd_valid && !vol_lock &&
       !ind_lock && b == lcd_cmd_pkg::CMD_RESET) |=> ##1 sleep_mode;
  endproperty
  a_reset_sb: assert property (p_reset_sb) else $error("reset sb");

  property p_test_exit;
    @(posedge ref_clk) disable iff (!rst_n)
      (cmd_valid && !vol_lock && !ind_lock &&
       b == lcd_cmd_pkg::CMD_RESET) |=> !test_mode;
  endproperty
  a_test_exit: assert property (p_test_exit) else $error("test exit");

  property p_nop;
    @(posedge ref_clk) disable iff (!rst_n)
      (cmd_valid && !vol_lock && !ind_lock && b == lcd_cmd_pkg::CMD_NOP) |=>
        ($stable(level_value_bits) && $stable(indicator_mode) &&
         $stable(display_on) && $stable(all_on) && $stable(test_mode));
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");
endmodule : lcd_cmd_decoder

// *** rtl/lcd_cmd_pkg.sv ***
// Package with command codes, field layouts and timing constants.
package lcd_cmd_pkg;
  localparam logic [7:0] CMD_VOL_MODE = 8'h81;
  localparam logic [7:0] CMD_IND_MASK = 8'hfe;
  localparam logic [7:0] CMD_IND = 8'hac;
  localparam logic [7:0] CMD_DISP_MASK = 8'hfe;
  localparam logic [7:0] CMD_DISP = 8'hae;
  localparam logic [7:0] CMD_ALLON = 8'ha4;
  localparam logic [7:0] CMD_RESET = 8'he2;
  localparam logic [7:0] CMD_NOP = 8'he3;
  localparam logic [7:0] CMD_TEST_MASK = 8'hf0;
  localparam logic [7:0] CMD_TEST = 8'hf0;
  localparam int LEVEL_MSB = 5;
  localparam int SEL_BIT = 0;
  localparam logic [5:0] LEVEL_RESET = 6'h20;
  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_HALF = 2'h1;
  localparam logic [1:0] IND_ONE = 2'h2;
  localparam logic [1:0] IND_STEADY = 2'h3;
  localparam int CLK_HZ = 200_000_000;
  localparam int HALF_PERIOD_MS = 500;
  localparam int ONE_PERIOD_MS = 1000;
  localparam int HALF_CYCLES = CLK_HZ / 1000 * HALF_PERIOD_MS;
  localparam int ONE_CYCLES = CLK_HZ / 1000 * ONE_PERIOD_MS;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_STANDBY
  } power_type;

  typedef struct packed {
    logic valid;
    logic cmd_data_select;
    logic [7:0] data;
  } host_byte_type;
endpackage : lcd_cmd_pkg

// *** test/host_model.sv ***
// Host processor model that issues command and data bytes.
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk,
  output lcd_cmd_pkg::host_byte_type host_in
);
  initial begin
    host_in = '0;
  end

  // Idle data shows the inverse of the last byte, never a stale copy.
  task automatic send(input logic sel, input logic [7:0] b);
    @(posedge ref_clk);
    #1;
    host_in = {1'b1, sel, b};
    @(posedge ref_clk);
    #1;
    host_in = {1'b0, sel, ~b};
  endtask : send

  // Both bytes leave with one idle cycle between them, no other byte in between.
  task automatic pair(input logic [7:0] a, input logic [7:0] b);
    send(1'b0, a);
    send(1'b0, b);
  endtask : pair
endmodule : host_model

// *** test/testbench.sv ***
// Self-checking bench for the command interpreter.
`timescale 1ns/1ps
module testbench;
  logic ref_clk;
  logic resetn;
  lcd_cmd_pkg::host_byte_type host_in;
  logic [5:0] level_value_bits;
  logic [1:0] indicator_mode;
  logic indicator_on, indicator_drive_out, display_on, all_on;
  logic osc_run, supply_run, matrix_ground, sleep_mode, standby_mode;
  logic test_mode, host_port_ready;
  int error_cnt;
  int cmp_count;

  lcd_cmd_decoder #(.HALF_PERIOD(4), .ONE_PERIOD(8)) lcd_cmd_decoder_i (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .host_in(host_in),
    .level_value_bits(level_value_bits),
    .indicator_mode(indicator_mode),
    .indicator_on(indicator_on),
    .indicator_drive_out(indicator_drive_out),
    .display_on(display_on),
    .all_on(all_on),
    .osc_run(osc_run),
    .supply_run(supply_run),
    .matrix_ground(matrix_ground),
    .sleep_mode(sleep_mode),
    .standby_mode(standby_mode),
    .test_mode(test_mode),
    .host_port_ready(host_port_ready)
  );

  host_model host_model_i (
    .ref_clk(ref_clk),
    .host_in(host_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] b);
    host_model_i.send(1'b0, b);
  endtask : cmd

  // Power outputs lag the byte by two edges, so four is a safe margin.
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic pwr(input logic [4:0] exp);
    settle();
    chk("power", {3'd0, osc_run, supply_run, matrix_ground, sleep_mode,
        standby_mode}, {3'd0, exp});
  endtask : pwr

  task automatic pad_reset();
    resetn = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : pad_reset

  // Counts drive toggles over 40 cycles with the given blink code.
  task automatic blink(input logic [7:0] code, input int lo, input int hi);
    int f;
    logic last;
    host_model_i.pair(8'had, code);
    settle();
    f = 0;
    last = indicator_drive_out;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      if (indicator_drive_out !== last) f++;
      last = indicator_drive_out;
    end
    chk("blink", 8'd1, {7'd0, f >= lo && f <= hi});
  endtask : blink

  task automatic t_reset();
    pwr(5'b11000);
    chk("level", 8'h20, {2'd0, level_value_bits});
    chk("flags", 8'h01, {3'd0, indicator_on, display_on, all_on,
        test_mode, host_port_ready});
    $display("test reset done");
  endtask : t_reset

  task automatic t_volume();
    host_model_i.pair(8'h81, 8'hff);
    settle();
    chk("level", 8'h3f, {2'd0, level_value_bits});
    cmd(8'h81);
    host_model_i.send(1'b1, 8'h15);
    cmd(8'haf);
    settle();
    chk("level", 8'h2f, {2'd0, level_value_bits});
    chk("display", 8'h00, {7'd0, display_on});
    cmd(8'haf);
    settle();
    chk("display", 8'h01, {7'd0, display_on});
    cmd(8'hae);
    host_model_i.pair(8'h81, 8'h20);
    $display("test volume done");
  endtask : t_volume

  task automatic t_indicator();
    host_model_i.pair(8'had, 8'haf);
    settle();
    chk("ind", 8'h07, {5'd0, indicator_on, indicator_mode});
    chk("display", 8'h00, {7'd0, display_on});
    cmd(8'hac);
    settle();
    chk("ind_on", 8'h00, {7'd0, indicator_on});
    host_model_i.pair(8'had, 8'hfe);
    cmd(8'ha7);
    cmd(8'haf);
    cmd(8'hae);
    settle();
    chk("ind", 8'h06, {5'd0, indicator_on, indicator_mode});
    blink(8'h01, 9, 11);
    blink(8'h02, 4, 6);
    blink(8'h03, 0, 0);
    host_model_i.pair(8'had, 8'h00);
    cmd(8'hac);
    $display("test indicator done");
  endtask : t_indicator

  task automatic t_power();
    cmd(8'ha5);
    pwr(5'b00110);
    chk("all_on", 8'h01, {7'd0, all_on});
    host_model_i.pair(8'h81, 8'h11);
    settle();
    chk("level", 8'h11, {2'd0, level_value_bits});
    chk("ready", 8'h01, {7'd0, host_port_ready});
    cmd(8'haf);
    pwr(5'b00110);
    host_model_i.pair(8'had, 8'h01);
    pwr(5'b11000);
    cmd(8'hae);
    pwr(5'b10101);
    blink(8'h01, 9, 11);
    cmd(8'he2);
    pwr(5'b00110);
    cmd(8'ha4);
    pwr(5'b00110);
    host_model_i.pair(8'had, 8'h01);
    pwr(5'b11000);
    $display("test power done");
  endtask : t_power

  task automatic t_test();
    cmd(8'hf7);
    settle();
    chk("test", 8'h01, {7'd0, test_mode});
    cmd(8'he3);
    settle();
    chk("test", 8'h01, {7'd0, test_mode});
    chk("level", 8'h20, {2'd0, level_value_bits});
    cmd(8'he2);
    settle();
    chk("test", 8'h00, {7'd0, test_mode});
    cmd(8'hf3);
    settle();
    chk("test", 8'h01, {7'd0, test_mode});
    pad_reset();
    chk("test", 8'h00, {7'd0, test_mode});
    cmd(8'hf5);
    settle();
    chk("test", 8'h01, {7'd0, test_mode});
    cmd(8'hf0);
    settle();
    chk("test", 8'h00, {7'd0, test_mode});
    $display("test testmode done");
  endtask : t_test

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    pad_reset();
    t_reset();
    t_volume();
    t_indicator();
    t_power();
    t_test();
    final_report();
  end
endmodule : testbench
